// ---- src/rst_idle_pkg.sv ----
package rst_idle_pkg;
  localparam int unsigned DELAY_BITS     = 17;
  localparam logic [16:0] DELAY_TERMINAL = 17'h1_FFFF;
  localparam logic [16:0] DELAY_RESET    = 17'h0_0000;
  localparam int unsigned IDLE_BIT       = 0;
  localparam int unsigned WAKE_SRC_N     = 3;
  localparam int unsigned WAKE_EXT       = 0;
  localparam int unsigned WAKE_WDT       = 1;
  localparam int unsigned WAKE_AUX       = 2;
  localparam logic [7:0]  PWR_CTRL_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SERIAL_PROG,
    MODE_PARALLEL_PROG
  } boot_mode_type;

  typedef enum {
    ST_RESET,
    ST_DELAY,
    ST_RUN,
    ST_IDLE
  } seq_state_type;

  typedef struct packed {
    logic external_access;
    logic program_store_strobe;
    logic address_latch;
  } strap_type;

  typedef struct packed {
    logic [2:0] enable;
    logic [2:0] request;
  } wake_type;
endpackage : rst_idle_pkg

// ---- src/power_delay_counter.sv ----
`timescale 1ns/100ps
module power_delay_counter #(
  parameter logic [16:0] TERMINAL = rst_idle_pkg::DELAY_TERMINAL  // last count before done
) (
  input  wire logic clk_sys,  // system clock
  input  wire logic rst,      // synchronous reset
  input  wire logic restart,  // hold counter at zero
  output logic      done      // delay expired
);
  import rst_idle_pkg::*;

  typedef struct packed {
    logic [16:0] count;
    logic        done;
  } cnt_state_type;

  cnt_state_type state_q;
  cnt_state_type state_d;

  always_comb begin
    state_d = state_q;
    if (restart) begin
      state_d.count = DELAY_RESET;
      state_d.done  = 1'b0;
    end else if (!state_q.done) begin
      if (state_q.count == TERMINAL) begin
        state_d.done = 1'b1;
      end else begin
        state_d.count = state_q.count + 17'h0_0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign done = state_q.done;
endmodule : power_delay_counter

// ---- src/reset_strap_idle.sv ----
`timescale 1ns/100ps
// Summary of operation
// RULE_01 - sample external access pin during reset in normal mode for code protection
// RULE_02 - while reset high, enable weak pull-ups on strobe and latch pins
// RULE_03 - after reset sequence, drop pull-ups and let cpu drive both pins
// RULE_04 - in flash programming mode ignore the external access pin level
// RULE_05 - writing one to power control bit zero enters idle immediately
// RULE_06 - leave idle only on system reset or enabled interrupt
// RULE_07 - external, watchdog and auxiliary interrupts can each wake from idle
// RULE_08 - on wake run interrupt service, then resume after idling instruction
// RULE_09 - hold cpu start until seventeen bit delay counter runs out
// RULE_10 - latch pin straps at reset release, hold until next reset
module reset_strap_idle #(
  parameter logic [16:0] DELAY_LAST = rst_idle_pkg::DELAY_TERMINAL  // last start-up count
) (
  input  wire logic                   clk_sys,         // system clock, 20 MHz
  input  wire logic                   rst,             // reset pin, active high
  input  wire rst_idle_pkg::strap_type pin_in,         // pad levels of the three pins
  input  wire logic                   cpu_strobe,      // cpu drive for strobe pin
  input  wire logic                   cpu_latch,       // cpu drive for latch pin
  input  wire logic                   pwr_wr,          // power control register write
  input  wire logic [7:0]             pwr_wdata,       // power control write data
  input  wire rst_idle_pkg::wake_type wake,            // interrupt enables and requests
  input  wire logic                   isr_done,        // return from wake service routine
  output logic                        strobe_out,      // strobe pin output value
  output logic                        strobe_oe,       // strobe pin output enable
  output logic                        latch_out,       // latch pin output value
  output logic                        latch_oe,        // latch pin output enable
  output logic                        pullup_en,       // weak pull-ups on strobe and latch
  output logic                        code_protect,    // derived from external access strap
  output rst_idle_pkg::boot_mode_type boot_mode,       // latched programming mode
  output logic                        cpu_run,         // cpu may execute
  output logic                        idle,            // idle mode, cpu_run low until wake or reset
  output logic                        wake_irq,        // vector to service routine
  output logic [7:0]                  pwr_ctrl         // power control register value
);
  import rst_idle_pkg::*;

  typedef struct packed {
    seq_state_type seq;
    strap_type     strap;
    boot_mode_type mode;
    logic          protect;
    logic [7:0]    power_control_register;
    logic          in_isr;
    logic          irq;
  } blk_state_type;

  blk_state_type state_q;
  blk_state_type state_d;
  logic          delay_done;
  logic          wake_hit;

  function automatic boot_mode_type decode_mode(input strap_type s);
    if (!s.program_store_strobe && s.address_latch) begin
      return MODE_SERIAL_PROG;
    end else if (!s.program_store_strobe && !s.address_latch) begin
      return MODE_PARALLEL_PROG;
    end
    return MODE_NORMAL;
  endfunction : decode_mode

  // RULE_09 start-up delay
  power_delay_counter #(
    .TERMINAL (DELAY_LAST)
  ) u_delay (
    .clk_sys (clk_sys),
    .rst     (rst),
    .restart (state_q.seq == ST_RESET),
    .done    (delay_done)
  );

  // RULE_07 wake sources
  assign wake_hit = |(wake.enable & wake.request);

  always_comb begin
    state_d     = state_q;
    state_d.irq = 1'b0;
    unique case (state_q.seq)
      ST_RESET: begin
        state_d.seq = ST_DELAY;
      end
      ST_DELAY: begin
        // RULE_01 sample during sequence
        state_d.strap = pin_in;
        if (delay_done) begin
          // RULE_10 latch at release
          state_d.mode = decode_mode(state_q.strap);
          // RULE_04 ignore access pin
          state_d.protect = (decode_mode(state_q.strap) == MODE_NORMAL) ?
                            !state_q.strap.external_access : 1'b0;
          state_d.seq = ST_RUN;
        end
      end
      ST_RUN: begin
        if (state_q.in_isr && isr_done) begin
          state_d.in_isr = 1'b0;
        end
        // RULE_05 enter idle
        if (pwr_wr && pwr_wdata[IDLE_BIT]) begin
          state_d.power_control_register = pwr_wdata;
          state_d.seq  = ST_IDLE;
        end else if (pwr_wr) begin
          state_d.power_control_register = pwr_wdata;
        end
      end
      ST_IDLE: begin
        // RULE_06 only enabled interrupt or reset exits
        if (wake_hit) begin
          // RULE_08 service first, then resume
          state_d.power_control_register[IDLE_BIT] = 1'b0;
          state_d.in_isr         = 1'b1;
          state_d.irq            = 1'b1;
          state_d.seq            = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q.seq     <= ST_RESET;
      state_q.strap   <= '0;
      state_q.mode    <= MODE_NORMAL;
      state_q.protect <= 1'b0;
      state_q.power_control_register    <= PWR_CTRL_RESET;
      state_q.in_isr  <= 1'b0;
      state_q.irq     <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // RULE_02 pull-ups in reset
  assign pullup_en    = (state_q.seq == ST_RESET) || (state_q.seq == ST_DELAY);
  // RULE_03 cpu drives pins
  assign strobe_oe    = !pullup_en;
  assign latch_oe     = !pullup_en;
  assign strobe_out   = pullup_en ? 1'b1 : cpu_strobe;
  assign latch_out    = pullup_en ? 1'b1 : cpu_latch;
  assign code_protect = state_q.protect;
  assign boot_mode    = state_q.mode;
  assign cpu_run      = (state_q.seq == ST_RUN);
  assign idle         = (state_q.seq == ST_IDLE);
  assign wake_irq     = state_q.irq;
  assign pwr_ctrl     = state_q.power_control_register;

  sequence s_idle_write;
    cpu_run && pwr_wr && pwr_wdata[IDLE_BIT];
  endsequence

  sequence s_wake;
    idle && wake_hit;
  endsequence

  sequence s_release;
    $fell(pullup_en);
  endsequence

  sequence s_idle_refused;
    idle && pwr_wr && !wake_hit;
  endsequence

  a_idle_entry_now: assert property (@(posedge clk_sys) disable iff (rst) // RULE_05
    s_idle_write |=> idle)
    else $error("idle not entered after idle bit write");

  a_idle_stays_put: assert property (@(posedge clk_sys) disable iff (rst) // RULE_06
    idle && !wake_hit |=> idle)
    else $error("idle left without enabled interrupt");

  a_wake_enabled_src: assert property (@(posedge clk_sys) disable iff (rst) // RULE_07
    s_wake |=> cpu_run && wake_irq)
    else $error("enabled interrupt did not wake");

  a_wake_isr_first: assert property (@(posedge clk_sys) disable iff (rst) // RULE_08
    $rose(cpu_run) && $past(idle) |-> wake_irq && !pwr_ctrl[IDLE_BIT])
    else $error("wake did not vector to service routine");

  a_pullup_reset: assert property (@(posedge clk_sys) // RULE_02
    rst |=> pullup_en && !strobe_oe && !latch_oe)
    else $error("pull-ups not on after reset");

  a_pins_to_cpu: assert property (@(posedge clk_sys) disable iff (rst) // RULE_03
    cpu_run |-> !pullup_en && strobe_oe && latch_oe && strobe_out == cpu_strobe)
    else $error("pins not handed to cpu");

  a_start_delay: assert property (@(posedge clk_sys) disable iff (rst) // RULE_09
    $rose(cpu_run) && !$past(idle) |-> $past(delay_done))
    else $error("cpu started before delay");

  a_prog_ignores_ea: assert property (@(posedge clk_sys) disable iff (rst) // RULE_04
    boot_mode != MODE_NORMAL |-> !code_protect)
    else $error("access pin used in programming mode");

  a_strap_hold: assert property (@(posedge clk_sys) disable iff (rst) // RULE_10
    !pullup_en && $past(!pullup_en) |-> $stable(boot_mode) && $stable(code_protect))
    else $error("strap changed outside reset");

  a_protect_from_strap: assert property (@(posedge clk_sys) disable iff (rst) // RULE_01
    s_release |-> boot_mode != MODE_NORMAL || code_protect == !$past(pin_in.external_access, 2))
    else $error("protect not taken from access strap");

  a_strap_mode_map: assert property (@(posedge clk_sys) disable iff (rst) // RULE_10
    s_release |-> (boot_mode == MODE_NORMAL) == $past(pin_in.program_store_strobe, 2))
    else $error("boot mode not taken from strobe strap");

  a_pullup_off_run: assert property (@(posedge clk_sys) disable iff (rst) // RULE_03
    s_release |-> cpu_run && strobe_oe && latch_oe && latch_out == cpu_latch)
    else $error("pins not released to cpu at start");

  a_pullup_in_reset: assert property (@(posedge clk_sys) disable iff (rst) // RULE_02
    !cpu_run && !idle |-> pullup_en && !strobe_oe && !latch_oe)
    else $error("pull-ups off during reset sequence");

  a_run_needs_delay: assert property (@(posedge clk_sys) disable iff (rst) // RULE_09
    cpu_run |-> delay_done)
    else $error("cpu running without expired delay");

  a_irq_single: assert property (@(posedge clk_sys) disable iff (rst) // RULE_08
    wake_irq |=> !wake_irq)
    else $error("wake vector longer than one cycle");

  a_idle_write_refused: assert property (@(posedge clk_sys) disable iff (rst) // RULE_06
    s_idle_refused |=> idle && $stable(pwr_ctrl))
    else $error("power control write taken in idle");

  a_disabled_ignored: assert property (@(posedge clk_sys) disable iff (rst) // RULE_07
    idle && (wake.enable & wake.request) == 3'b000 |=> idle)
    else $error("disabled interrupt woke from idle");
endmodule : reset_strap_idle

// ---- tb/strap_board.sv ----
`timescale 1ns/100ps
module strap_board (
  input  wire logic         ea_level,   // board level of access pin
  input  wire logic         strobe_low, // programmer holds strobe low
  input  wire logic         latch_low,  // programmer holds latch low
  input  wire logic         strobe_out, // device strobe value
  input  wire logic         strobe_oe,  // device strobe enable
  input  wire logic         latch_out,  // device latch value
  input  wire logic         latch_oe,   // device latch enable
  input  wire logic         pullup_en,  // device weak pull-ups
  output rst_idle_pkg::strap_type pin_in // resolved pad levels
);
  import rst_idle_pkg::*;
  always_comb begin
    pin_in.external_access      = ea_level;
    pin_in.program_store_strobe = strobe_oe ? strobe_out : (!strobe_low && pullup_en);
    pin_in.address_latch        = latch_oe ? latch_out : (!latch_low && pullup_en);
  end
endmodule : strap_board

// ---- tb/reset_strap_and_idle_control_tb.sv ----
`timescale 1ns/100ps
module reset_strap_and_idle_control_tb;
  import rst_idle_pkg::*;
  logic          clk_sys, rst, cpu_strobe, cpu_latch, pwr_wr, isr_done;
  logic          ea_level, strobe_low, latch_low, strobe_out, strobe_oe;
  logic          latch_out, latch_oe, pullup_en, code_protect, cpu_run, idle, wake_irq;
  logic [7:0]    pwr_wdata, pwr_ctrl;
  wake_type      wake;
  strap_type     pin_in;
  boot_mode_type boot_mode;
  int            errors, num_checks;
  localparam logic [16:0] SHORT_DELAY = 17'h0_03FF;  // shortened start-up count

  strap_board u_board (.ea_level(ea_level), .strobe_low(strobe_low), .latch_low(latch_low),
    .strobe_out(strobe_out), .strobe_oe(strobe_oe), .latch_out(latch_out),
    .latch_oe(latch_oe), .pullup_en(pullup_en), .pin_in(pin_in));
  reset_strap_idle #(.DELAY_LAST(SHORT_DELAY)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .pin_in(pin_in),
    .cpu_strobe(cpu_strobe), .cpu_latch(cpu_latch), .pwr_wr(pwr_wr), .pwr_wdata(pwr_wdata),
    .wake(wake), .isr_done(isr_done), .strobe_out(strobe_out), .strobe_oe(strobe_oe),
    .latch_out(latch_out), .latch_oe(latch_oe), .pullup_en(pullup_en),
    .code_protect(code_protect), .boot_mode(boot_mode), .cpu_run(cpu_run), .idle(idle),
    .wake_irq(wake_irq), .pwr_ctrl(pwr_ctrl));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // reset with given straps, wait for start, then let go of straps
  task automatic boot(input logic ea, input logic sl, input logic ll);
    int n;
    @(posedge clk_sys);
    rst        <= 1'b1;
    ea_level   <= ea;
    strobe_low <= sl;
    latch_low  <= ll;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    check({3'h0, pullup_en, strobe_oe, latch_oe, cpu_run, idle}, 8'h10);
    check(pwr_ctrl, 8'h00);
    @(posedge clk_sys);
    rst <= 1'b0;
    n = 0;
    while (cpu_run !== 1'b1 && n < 4096) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 4096) begin
      errors++;
      complete_run();
    end
    check(8'(n >= int'(SHORT_DELAY) && n <= int'(SHORT_DELAY) + 512), 8'h01);
    @(posedge clk_sys);
    ea_level   <= ~ea;
    strobe_low <= 1'b0;
    latch_low  <= 1'b0;
    cpu_strobe <= 1'b0;
    cpu_latch  <= 1'b1;
    repeat (3) @(negedge clk_sys);
    check({3'h0, strobe_out, latch_out, strobe_oe, latch_oe, pullup_en}, 8'h0E);
  endtask : boot

  task automatic idle_wake(input int src);
    @(posedge clk_sys);
    pwr_wr    <= 1'b1;
    pwr_wdata <= 8'h01;
    @(posedge clk_sys);
    pwr_wr <= 1'b0;
    wake   <= {3'b000, 3'b001 << src};
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check({5'h0, idle, cpu_run, pwr_ctrl[0]}, 8'h05);
    check({7'h0, idle}, 8'h01);
    @(posedge clk_sys);
    wake.enable <= 3'b001 << src;
    @(posedge clk_sys);
    wake <= '0;
    @(negedge clk_sys);
    check({4'h0, idle, cpu_run, wake_irq, pwr_ctrl[0]}, 8'h06);
    @(negedge clk_sys);
    check({6'h0, wake_irq, cpu_run}, 8'h01);
    @(posedge clk_sys);
    isr_done <= 1'b1;
    @(posedge clk_sys);
    isr_done <= 1'b0;
  endtask : idle_wake

  // idle left by reset only, writes refused while idle
  task automatic idle_then_reset();
    @(posedge clk_sys);
    pwr_wr    <= 1'b1;
    pwr_wdata <= 8'h81;
    @(posedge clk_sys);
    pwr_wdata <= 8'h00;
    @(posedge clk_sys);
    pwr_wr <= 1'b0;
    @(negedge clk_sys);
    check(pwr_ctrl, 8'h81);
    check({6'h0, idle, cpu_run}, 8'h02);
    boot(1'b0, 1'b1, 1'b0);
    check({5'h0, code_protect, boot_mode}, {5'h0, 1'b0, MODE_SERIAL_PROG});
  endtask : idle_then_reset

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    {rst, cpu_strobe, cpu_latch, pwr_wr, isr_done, ea_level, strobe_low, latch_low} = 8'h80;
    pwr_wdata  = 8'h00;
    wake       = '0;
    errors     = 0;
    num_checks = 0;
    boot(1'b0, 1'b0, 1'b0);
    check({5'h0, code_protect, boot_mode}, {5'h0, 1'b1, MODE_NORMAL});
    repeat (5) @(negedge clk_sys);
    check({5'h0, code_protect, boot_mode}, {5'h0, 1'b1, MODE_NORMAL});
    for (int i = 0; i < 3; i++) idle_wake(i);
    idle_then_reset();
    boot(1'b0, 1'b1, 1'b1);
    check({5'h0, code_protect, boot_mode}, {5'h0, 1'b0, MODE_PARALLEL_PROG});
    complete_run();
  end
endmodule : reset_strap_and_idle_control_tb
